// ### hw/mitc_params.svh
// Constants of the instruction timing core: word layout, sizes and fixed addresses.
`ifndef MITC_PARAMS_SVH
`define MITC_PARAMS_SVH
`define MITC_WORD_W 17
`define MITC_OP_HI 16
`define MITC_OP_LO 11
`define MITC_BIT_HI 10
`define MITC_BIT_LO 8
`define MITC_PC_W 11
`define MITC_STK_DEPTH 6
`define MITC_PCL_ADDR 8'h06
`define MITC_INT_VEC 11'h004
`endif

// ### hw/mitc_pkg.sv
// Types shared by the instruction timing core and its arithmetic unit.
`include "mitc_params.svh"
package mitc_pkg;
    typedef logic [7:0] mitc_byte_t;
    typedef enum logic [`MITC_OP_HI-`MITC_OP_LO:0] {
        OP_NOP, OP_DATA_TRANSFER_AM, OP_DATA_TRANSFER_MA, OP_DATA_TRANSFER_AX, OP_CLEAR_M,
        OP_ADD_AM, OP_ADD_MA, OP_ADD_AX, OP_ADDC_AM, OP_SUB_AM, OP_SUB_MA, OP_SUB_AX,
        OP_SUBC_AM, OP_AND_AM, OP_OR_AM, OP_XOR_AM, OP_AND_MA, OP_OR_MA, OP_XOR_MA,
        OP_ONES_COMPLEMENT, OP_ONES_COMPLEMENT_A, OP_ADD_ONE_IN_PLACE, OP_ADD_ONE_TO_ACC,
        OP_SUBTRACT_ONE_IN_PLACE, OP_SUBTRACT_ONE_TO_ACC, OP_ROTATE_RIGHT, OP_ROTATE_LEFT,
        OP_ROTATE_RIGHT_VIA_CARRY, OP_ROTATE_LEFT_VIA_CARRY, OP_SKIP_ZERO,
        OP_SKIP_BIT_CLEAR, OP_SKIP_BIT_SET, OP_BIT_SET, OP_BIT_CLEAR,
        OP_UNCONDITIONAL_JUMP, OP_CALL, OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT, OP_TABLE_READ
    } mitc_op_e;
    typedef enum logic [1:0] {PH_FETCH, PH_DECODE, PH_READ, PH_EXEC} mitc_phase_e;
endpackage : mitc_pkg

// ### hw/mitc_alu_if.sv
// Operand and result bundle between the sequencer and the arithmetic unit.
`timescale 1ns/100ps
`default_nettype none
interface mitc_alu_if;
    import mitc_pkg::*;
    mitc_op_e op;
    mitc_byte_t a;
    mitc_byte_t m;
    mitc_byte_t x;
    logic [2:0] bsel;
    logic cin;
    mitc_byte_t res;
    logic cout;
    logic c_we;
    logic z_we;
    logic to_acc;
    logic to_mem;
    logic skip;
    modport core (output op, a, m, x, bsel, cin,
                  input res, cout, c_we, z_we, to_acc, to_mem, skip);
    modport alu (input op, a, m, x, bsel, cin,
                 output res, cout, c_we, z_we, to_acc, to_mem, skip);
endinterface : mitc_alu_if
`default_nettype wire

// ### hw/mitc_alu.sv
// Combinational data path: moves, arithmetic, logic, rotates, bit ops and skip tests.
`timescale 1ns/100ps
`default_nettype none
module mitc_alu (
    mitc_alu_if.alu bus
);
    import mitc_pkg::*;
    logic [8:0] sum9;
    mitc_byte_t opnd;
    mitc_byte_t r;
    mitc_byte_t bmask;
    logic co;
    logic sk;

    // Destination and flag decode kept apart from the value so each op is listed once.
    assign bus.to_acc = bus.op inside {OP_DATA_TRANSFER_AM, OP_DATA_TRANSFER_AX, OP_ADD_AM,
        OP_ADD_AX, OP_ADDC_AM, OP_SUB_AM, OP_SUB_AX, OP_SUBC_AM, OP_AND_AM, OP_OR_AM,
        OP_XOR_AM, OP_ONES_COMPLEMENT_A, OP_ADD_ONE_TO_ACC, OP_SUBTRACT_ONE_TO_ACC};
    assign bus.to_mem = bus.op inside {OP_DATA_TRANSFER_MA, OP_CLEAR_M, OP_ADD_MA, OP_SUB_MA,
        OP_AND_MA, OP_OR_MA, OP_XOR_MA, OP_ONES_COMPLEMENT, OP_ADD_ONE_IN_PLACE,
        OP_SUBTRACT_ONE_IN_PLACE, OP_ROTATE_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT_VIA_CARRY,
        OP_ROTATE_LEFT_VIA_CARRY, OP_BIT_SET, OP_BIT_CLEAR};
    assign bus.c_we = bus.op inside {OP_ADD_AM, OP_ADD_MA, OP_ADD_AX, OP_ADDC_AM, OP_SUB_AM,
        OP_SUB_MA, OP_SUB_AX, OP_SUBC_AM, OP_ROTATE_RIGHT_VIA_CARRY, OP_ROTATE_LEFT_VIA_CARRY};
    assign bus.z_we = bus.op inside {OP_ADD_AM, OP_ADD_MA, OP_ADD_AX, OP_ADDC_AM, OP_SUB_AM,
        OP_SUB_MA, OP_SUB_AX, OP_SUBC_AM, OP_AND_AM, OP_OR_AM, OP_XOR_AM, OP_AND_MA,
        OP_OR_MA, OP_XOR_MA, OP_ONES_COMPLEMENT, OP_ONES_COMPLEMENT_A, OP_ADD_ONE_IN_PLACE,
        OP_ADD_ONE_TO_ACC, OP_SUBTRACT_ONE_IN_PLACE, OP_SUBTRACT_ONE_TO_ACC};
    assign bus.res = r;
    assign bus.cout = co;
    assign bus.skip = sk;

    // Result value; the immediate forms take the operand byte in place of memory.
    always_comb begin
        sum9 = 9'h000;
        opnd = bus.op inside {OP_ADD_AX, OP_SUB_AX} ? bus.x : bus.m;
        bmask = 8'h01 << bus.bsel;
        r = 8'h00;
        co = bus.cin;
        sk = 1'b0;
        unique case (bus.op)
            OP_DATA_TRANSFER_AM: r = bus.m;
            OP_DATA_TRANSFER_MA: r = bus.a;
            OP_DATA_TRANSFER_AX: r = bus.x;
            OP_ADD_AM, OP_ADD_MA, OP_ADD_AX, OP_ADDC_AM: begin
                sum9 = {1'b0, bus.a} + {1'b0, opnd} + {8'h00, bus.op == OP_ADDC_AM && bus.cin};
                r = sum9[7:0];
                co = sum9[8];
            end
            OP_SUB_AM, OP_SUB_MA, OP_SUB_AX, OP_SUBC_AM: begin
                sum9 = {1'b0, bus.a} - {1'b0, opnd} - {8'h00, bus.op == OP_SUBC_AM && !bus.cin};
                r = sum9[7:0];
                co = !sum9[8]; // Carry low means a borrow happened.
            end
            OP_AND_AM, OP_AND_MA: r = bus.a & bus.m;
            OP_OR_AM, OP_OR_MA: r = bus.a | bus.m;
            OP_XOR_AM, OP_XOR_MA: r = bus.a ^ bus.m;
            OP_ONES_COMPLEMENT, OP_ONES_COMPLEMENT_A: r = ~bus.m;
            OP_ADD_ONE_IN_PLACE, OP_ADD_ONE_TO_ACC: r = bus.m + 8'h01;
            OP_SUBTRACT_ONE_IN_PLACE, OP_SUBTRACT_ONE_TO_ACC: r = bus.m - 8'h01;
            OP_ROTATE_RIGHT: r = {bus.m[0], bus.m[7:1]};
            OP_ROTATE_LEFT: r = {bus.m[6:0], bus.m[7]};
            OP_ROTATE_RIGHT_VIA_CARRY: begin
                r = {bus.cin, bus.m[7:1]};
                co = bus.m[0];
            end
            OP_ROTATE_LEFT_VIA_CARRY: begin
                r = {bus.m[6:0], bus.cin};
                co = bus.m[7];
            end
            OP_SKIP_ZERO: sk = bus.m == 8'h00;
            OP_SKIP_BIT_CLEAR: sk = (bus.m & bmask) == 8'h00;
            OP_SKIP_BIT_SET: sk = (bus.m & bmask) != 8'h00;
            OP_BIT_SET: r = bus.m | bmask;
            OP_BIT_CLEAR: r = bus.m & ~bmask;
            default: r = 8'h00;
        endcase
    end
endmodule : mitc_alu
`default_nettype wire

// ### hw/mitc_core.sv
// Instruction sequencer: four-phase cycle, fetch, execute, program counter, stack, tables.
`timescale 1ns/100ps
`default_nettype none
`include "mitc_params.svh"
module mitc_core #(
    parameter int PC_W = `MITC_PC_W,
    parameter int STK_DEPTH = `MITC_STK_DEPTH,
    parameter logic [PC_W-1:0] INT_VEC = PC_W'(`MITC_INT_VEC)
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    output logic [PC_W-1:0] pmem_addr_out,
    input wire logic [`MITC_WORD_W-1:0] pmem_data_in,
    output var mitc_pkg::mitc_byte_t dmem_addr_out,
    output var mitc_pkg::mitc_byte_t dmem_wdata_out,
    output logic dmem_we_out,
    input wire mitc_pkg::mitc_byte_t dmem_rdata_in,
    input wire logic int_req_in,
    output logic int_ack_out,
    output var mitc_pkg::mitc_byte_t acc_out,
    output logic carry_out,
    output logic zero_out
);
    import mitc_pkg::*;
    localparam int SP_W = $clog2(STK_DEPTH + 1);
    localparam logic [SP_W-1:0] SP_FULL = SP_W'(STK_DEPTH);

    logic [1:0] rsync_q;
    logic rst_n;
    mitc_phase_e ph_q;
    logic [`MITC_WORD_W-1:0] ir_q;
    mitc_byte_t md_q;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;
    logic [PC_W-1:0] stk_q [STK_DEPTH];
    logic [SP_W-1:0] sp_q;
    logic bubble_q;
    logic tab_q;
    logic ie_q;
    mitc_op_e op;
    mitc_byte_t oper;
    logic [PC_W-1:0] top;
    logic exec;
    logic is_jump;
    logic is_call;
    logic is_exit;
    logic is_tab;
    logic pcl_wr;
    logic ctl;
    logic take_int;

    mitc_alu_if alu_bus ();
    mitc_alu u_alu (
        .bus(alu_bus)
    );

    // Reset is released through two flops so that its removal is clean on clk_in.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rsync_q <= 2'h0;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end
    assign rst_n = rsync_q[1];

    // Decode of the latched word and feed of the arithmetic unit.
    assign op = mitc_op_e'(ir_q[`MITC_OP_HI:`MITC_OP_LO]);
    assign oper = ir_q[7:0];
    assign alu_bus.op = op;
    assign alu_bus.a = acc_out;
    assign alu_bus.m = md_q;
    assign alu_bus.x = oper;
    assign alu_bus.bsel = ir_q[`MITC_BIT_HI:`MITC_BIT_LO];
    assign alu_bus.cin = carry_out;
    assign exec = (ph_q == PH_EXEC) && !bubble_q;
    assign is_jump = op == OP_UNCONDITIONAL_JUMP;
    assign is_call = op == OP_CALL;
    assign is_exit = op inside {OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT};
    assign is_tab = op == OP_TABLE_READ;
    assign pcl_wr = alu_bus.to_mem && (dmem_addr_out == `MITC_PCL_ADDR);
    assign ctl = is_jump || is_call || is_exit || is_tab || alu_bus.skip || pcl_wr;
    // Interrupts are taken only after a one-cycle instruction, so no push ever collides.
    assign take_int = int_req_in && ie_q && !ctl && (sp_q < SP_FULL);
    assign top = (sp_q != '0) ? stk_q[sp_q - SP_W'(1)] : pc_q;

    // Next program counter after an executed instruction.
    always_comb begin
        pc_d = pc_q + PC_W'(1);
        if (take_int) begin
            pc_d = INT_VEC;
        end else if (is_jump || is_call) begin
            pc_d = ir_q[PC_W-1:0];
        end else if (is_exit) begin
            pc_d = top;
        end else if (alu_bus.skip) begin
            pc_d = pc_q + PC_W'(2);
        end else if (pcl_wr) begin
            pc_d = {pc_q[PC_W-1:8], alu_bus.res};
        end
    end

    // Phase counter: the only rate divider; one instruction cycle is four clocks.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ph_q <= PH_FETCH;
        end else begin
            unique case (ph_q)
                PH_FETCH: ph_q <= PH_DECODE;
                PH_DECODE: ph_q <= PH_READ;
                PH_READ: ph_q <= PH_EXEC;
                PH_EXEC: ph_q <= PH_FETCH;
            endcase
        end
    end

    // Fetch path; in the spare cycle of a table read the address points into the table.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pmem_addr_out <= '0;
            ir_q <= '0;
            dmem_addr_out <= 8'h00;
            md_q <= 8'h00;
        end else if (ph_q == PH_FETCH) begin
            pmem_addr_out <= (bubble_q && tab_q) ? {{(PC_W-8){1'b1}}, oper} : pc_q;
        end else if (ph_q == PH_DECODE && !bubble_q) begin
            ir_q <= pmem_data_in;
            dmem_addr_out <= pmem_data_in[7:0];
        end else if (ph_q == PH_READ && !bubble_q) begin
            md_q <= dmem_rdata_in;
        end
    end

    // Sequencing state: counter, spare-cycle marker and global interrupt enable.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= '0;
            bubble_q <= 1'b0;
            tab_q <= 1'b0;
            ie_q <= 1'b1;
            int_ack_out <= 1'b0;
        end else begin
            int_ack_out <= exec && take_int;
            if (exec) begin
                pc_q <= pc_d;
                tab_q <= is_tab;
                if (take_int) begin
                    ie_q <= 1'b0;
                end else if (op == OP_INTERRUPT_EXIT) begin
                    ie_q <= 1'b1;
                end
            end
            if (ph_q == PH_EXEC) begin
                bubble_q <= exec && (ctl || take_int);
            end
        end
    end

    // Return stack holds the counter only; a push on a full stack is dropped.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sp_q <= '0;
            for (int i = 0; i < STK_DEPTH; i++) begin
                stk_q[i] <= '0;
            end
        end else if (exec && (is_call || take_int) && sp_q < SP_FULL) begin
            stk_q[sp_q] <= pc_q + PC_W'(1);
            sp_q <= sp_q + SP_W'(1);
        end else if (exec && is_exit && sp_q != '0) begin
            sp_q <= sp_q - SP_W'(1);
        end
    end

    // Accumulator, flags and the data memory write strobe.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            acc_out <= 8'h00;
            carry_out <= 1'b0;
            zero_out <= 1'b0;
            dmem_we_out <= 1'b0;
            dmem_wdata_out <= 8'h00;
        end else begin
            dmem_we_out <= exec && alu_bus.to_mem && !pcl_wr;
            if (exec) begin
                dmem_wdata_out <= alu_bus.res;
                if (alu_bus.to_acc) begin
                    acc_out <= alu_bus.res;
                end
                if (alu_bus.c_we) begin
                    carry_out <= alu_bus.cout;
                end
                if (alu_bus.z_we) begin
                    zero_out <= alu_bus.res == 8'h00;
                end
            end else if (ph_q == PH_DECODE && bubble_q && tab_q) begin
                acc_out <= pmem_data_in[7:0];
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    sequence s_four_phases;
        (ph_q == PH_FETCH) ##1 (ph_q == PH_DECODE) ##1 (ph_q == PH_READ) ##1 (ph_q == PH_EXEC);
    endsequence
    sequence s_two_cycles;
        (!exec) [*7] ##1 exec;
    endsequence

    phase_cycle_a: assert property ((ph_q == PH_FETCH) |-> s_four_phases ##1 (ph_q == PH_FETCH))
        else $error("instruction cycle is not four clocks");
    single_cycle_a: assert property (exec && !ctl && !take_int |=> (!exec) [*3] ##1 exec)
        else $error("ordinary instruction not one cycle");
    spare_cycle_a: assert property (exec && ctl |=> s_two_cycles)
        else $error("control instruction not two cycles");
    jump_target_a: assert property (exec && is_jump |=>
        pc_q == $past(ir_q[PC_W-1:0]) && $stable(sp_q))
        else $error("jump target or stack wrong");
    call_push_a: assert property (exec && is_call && sp_q < SP_FULL |=>
        pc_q == $past(ir_q[PC_W-1:0]) && sp_q == $past(sp_q) + SP_W'(1)
        && stk_q[$past(sp_q)] == $past(pc_q) + PC_W'(1))
        else $error("call did not push return address");
    exit_pop_a: assert property (exec && is_exit && sp_q != '0 |=> pc_q == $past(top))
        else $error("exit did not restore counter");
    pcl_jump_a: assert property (exec && pcl_wr |=>
        pc_q[7:0] == $past(alu_bus.res) && !dmem_we_out)
        else $error("low counter write did not jump");
    skip_taken_a: assert property (exec && alu_bus.skip |=> pc_q == $past(pc_q) + PC_W'(2))
        else $error("taken skip did not pass next word");
    table_fetch_a: assert property (exec && is_tab |=> ##1
        (pmem_addr_out == {{(PC_W-8){1'b1}}, oper}) ##1 (acc_out == $past(pmem_data_in[7:0])))
        else $error("table read address or data wrong");
    step_one_a: assert property (exec && op == OP_ADD_ONE_TO_ACC |=> acc_out == $past(md_q) + 8'h01)
        else $error("increment to accumulator wrong");
    zero_flag_a: assert property (exec && alu_bus.z_we |=> zero_out == ($past(alu_bus.res) == 8'h00))
        else $error("zero flag wrong");
    bit_set_a: assert property (exec && op == OP_BIT_SET |=> dmem_we_out
        && dmem_wdata_out == ($past(md_q) | (8'h01 << $past(alu_bus.bsel))))
        else $error("bit set changed other bits");
    add_carry_a: assert property (exec && op == OP_ADD_AM |=>
        carry_out == ($past({1'b0, acc_out} + {1'b0, md_q}) > 9'h0ff))
        else $error("add carry wrong");
    // The interrupted instruction still completes, so the accumulator may change here.
    int_entry_a: assert property (exec && take_int |=> int_ack_out && pc_q == INT_VEC
        && sp_q == $past(sp_q) + SP_W'(1)
        && stk_q[$past(sp_q)] == $past(pc_q) + PC_W'(1))
        else $error("interrupt entry wrong");
endmodule : mitc_core
`default_nettype wire

// ### sim/mitc_mem_model.sv
// Program and data memory arrays facing the memory ports of the core.
`timescale 1ns/100ps
`default_nettype none
`include "mitc_params.svh"
module mitc_mem_model (
    input wire logic clk_in,
    input wire logic [`MITC_PC_W-1:0] pmem_addr_in,
    output logic [`MITC_WORD_W-1:0] pmem_data_out,
    input wire mitc_pkg::mitc_byte_t dmem_addr_in,
    input wire mitc_pkg::mitc_byte_t dmem_wdata_in,
    input wire logic dmem_we_in,
    output var mitc_pkg::mitc_byte_t dmem_rdata_out
);
    import mitc_pkg::*;
    // Empty program words decode as no-operation.
    // Declaration values are set before any process starts, so a preload at time zero stays.
    logic [`MITC_WORD_W-1:0] prog [1<<`MITC_PC_W] = '{default: '0};
    mitc_byte_t dmem [256] = '{default: 8'h00};
    // Both arrays read without delay, because the core samples them in the same clock.
    assign pmem_data_out = prog[pmem_addr_in];
    assign dmem_rdata_out = dmem[dmem_addr_in];
    // A plain always block, because the bench also preloads the array between runs.
    always @(posedge clk_in) begin
        if (dmem_we_in) begin
            dmem[dmem_addr_in] <= dmem_wdata_in;
        end
    end
endmodule : mitc_mem_model
`default_nettype wire

// ### sim/mitc_instruction_timing_core_bench.sv
// Self-checking bench: one instruction per short program, timed against a no-op run.
`timescale 1ns/100ps
`default_nettype none
`include "mitc_params.svh"
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
    $display("BAD %s expected %h seen %h", nm, ex, gt); bad_count++; end end
module mitc_instruction_timing_core_bench;
    import mitc_pkg::*;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic int_req_in = 1'b0;
    logic [`MITC_PC_W-1:0] pmem_addr;
    logic [`MITC_WORD_W-1:0] pmem_data;
    mitc_byte_t dmem_addr, dmem_wdata, dmem_rdata, acc;
    logic dmem_we, int_ack, carry, zero;
    int bad_count = 0;
    int tests_run = 0;
    int base = 0;

    mitc_core i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .pmem_addr_out(pmem_addr),
        .pmem_data_in(pmem_data), .dmem_addr_out(dmem_addr), .dmem_wdata_out(dmem_wdata),
        .dmem_we_out(dmem_we), .dmem_rdata_in(dmem_rdata), .int_req_in(int_req_in),
        .int_ack_out(int_ack), .acc_out(acc), .carry_out(carry), .zero_out(zero));
    mitc_mem_model i_mem (.clk_in(clk_in), .pmem_addr_in(pmem_addr), .pmem_data_out(pmem_data),
        .dmem_addr_in(dmem_addr), .dmem_wdata_in(dmem_wdata), .dmem_we_in(dmem_we),
        .dmem_rdata_out(dmem_rdata));

    // System clock of 40 ns.
    initial begin
        forever #20 clk_in = ~clk_in;
    end

    // Expected results; carry enters as 0 because every run starts from reset.
    function automatic void expect_ops(input mitc_op_e op, input mitc_byte_t a, m, x, tb,
        input logic [2:0] b, output mitc_byte_t ra, rm, output logic rc, rz, output int dl);
        logic [8:0] t;
        ra = a;
        rm = m;
        dl = 0;
        t = 9'h000;
        case (op)
            OP_DATA_TRANSFER_AM, OP_ONES_COMPLEMENT_A: t = {1'b0, (op == OP_DATA_TRANSFER_AM) ? m : ~m};
            OP_DATA_TRANSFER_MA: t = {1'b0, a};
            OP_DATA_TRANSFER_AX: t = {1'b0, x};
            OP_ADD_AM, OP_ADD_MA, OP_ADDC_AM: t = {1'b0, a} + {1'b0, m};
            OP_ADD_AX: t = {1'b0, a} + {1'b0, x};
            OP_SUB_AM, OP_SUB_MA: t = {1'b0, a} + {1'b0, ~m} + 9'h001;
            OP_SUB_AX: t = {1'b0, a} + {1'b0, ~x} + 9'h001;
            OP_SUBC_AM: t = {1'b0, a} + {1'b0, ~m};
            OP_AND_AM, OP_AND_MA: t = {1'b0, a & m};
            OP_OR_AM, OP_OR_MA: t = {1'b0, a | m};
            OP_XOR_AM, OP_XOR_MA: t = {1'b0, a ^ m};
            OP_ONES_COMPLEMENT: t = {1'b0, ~m};
            OP_ADD_ONE_IN_PLACE, OP_ADD_ONE_TO_ACC: t = {1'b0, m + 8'h01};
            OP_SUBTRACT_ONE_IN_PLACE, OP_SUBTRACT_ONE_TO_ACC: t = {1'b0, m - 8'h01};
            OP_ROTATE_RIGHT: t = {1'b0, m[0], m[7:1]};
            OP_ROTATE_LEFT: t = {1'b0, m[6:0], m[7]};
            OP_ROTATE_RIGHT_VIA_CARRY: t = {m[0], 1'b0, m[7:1]};
            OP_ROTATE_LEFT_VIA_CARRY: t = {m[7], m[6:0], 1'b0};
            OP_BIT_SET: t = {1'b0, m | (8'h01 << b)};
            OP_BIT_CLEAR: t = {1'b0, m & ~(8'h01 << b)};
            OP_SKIP_ZERO: dl = (m == 8'h00) ? 4 : 0;
            OP_SKIP_BIT_CLEAR: dl = m[b] ? 0 : 4;
            OP_SKIP_BIT_SET: dl = m[b] ? 4 : 0;
            OP_TABLE_READ: t = {1'b0, tb};
            default: t = 9'h000;
        endcase
        if (op inside {OP_UNCONDITIONAL_JUMP, OP_CALL, OP_TABLE_READ}) dl = 4;
        if (op inside {OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT}) dl = 12;
        if (op inside {OP_DATA_TRANSFER_AM, OP_DATA_TRANSFER_AX, OP_ADD_AM, OP_ADD_AX, OP_ADDC_AM,
            OP_SUB_AM, OP_SUB_AX, OP_SUBC_AM, OP_AND_AM, OP_OR_AM, OP_XOR_AM, OP_TABLE_READ,
            OP_ONES_COMPLEMENT_A, OP_ADD_ONE_TO_ACC, OP_SUBTRACT_ONE_TO_ACC}) ra = t[7:0];
        if (op inside {OP_DATA_TRANSFER_MA, OP_CLEAR_M, OP_ADD_MA, OP_SUB_MA, OP_AND_MA,
            OP_OR_MA, OP_XOR_MA, OP_ONES_COMPLEMENT, OP_ADD_ONE_IN_PLACE, OP_BIT_SET,
            OP_SUBTRACT_ONE_IN_PLACE, OP_ROTATE_RIGHT, OP_ROTATE_LEFT, OP_BIT_CLEAR,
            OP_ROTATE_RIGHT_VIA_CARRY, OP_ROTATE_LEFT_VIA_CARRY}) rm = t[7:0];
        rz = (op inside {[OP_ADD_AM:OP_SUBTRACT_ONE_TO_ACC]}) && (t[7:0] == 8'h00);
        rc = (op inside {[OP_ADD_AM:OP_SUBC_AM], OP_ROTATE_RIGHT_VIA_CARRY,
            OP_ROTATE_LEFT_VIA_CARRY}) && t[8];
    endfunction : expect_ops

    // Releases reset and waits for the first store to the marker bytes f0 or f2.
    task automatic run(input logic irq, output int n, output mitc_byte_t where,
        output mitc_byte_t val, output int acks);
        n = 0;
        acks = 0;
        where = 8'h00;
        val = 8'h00;
        repeat (2) @(posedge clk_in);
        #1;
        nrst_in = 1'b1;
        int_req_in = irq;
        while (n < 300 && where == 8'h00) begin
            @(posedge clk_in);
            #1;
            n++;
            if (int_ack === 1'b1) begin
                acks++;
                int_req_in = 1'b0;
            end
            if (dmem_we === 1'b1 && dmem_addr[7:2] === 6'h3c) begin
                where = dmem_addr;
                val = dmem_wdata;
            end
        end
        if (where == 8'h00) begin
            $display("BAD marker expected store seen none");
            bad_count++;
        end
    endtask : run

    // Program: load a, instruction under test, stores at 2 and 3, interrupt handler at 4.
    task automatic try(input mitc_op_e op, input logic [2:0] b, input mitc_byte_t opd,
        input mitc_byte_t a, input mitc_byte_t m, input logic irq);
        logic [16:0] tb;
        mitc_byte_t ra, rm, where, val, land;
        logic rc, rz, program_counter_low;
        int dl, n, acks;
        tb = 17'($urandom);
        program_counter_low = (opd == 8'h06);
        nrst_in = 1'b0;
        i_mem.prog[0] = {6'(OP_DATA_TRANSFER_AX), 3'h0, a};
        i_mem.prog[1] = {6'(op), b, opd};
        if (op inside {OP_UNCONDITIONAL_JUMP, OP_CALL}) i_mem.prog[1] = {6'(op), 11'h003};
        if (dl == 0 && op inside {OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT})
            i_mem.prog[1] = {6'(OP_CALL), 11'h008};
        i_mem.prog[2] = {6'(OP_DATA_TRANSFER_MA), 3'h0, 8'hf2};
        i_mem.prog[3] = {6'(OP_DATA_TRANSFER_MA), 3'h0, 8'hf0};
        i_mem.prog[4] = {6'(OP_DATA_TRANSFER_MA), 3'h0, 8'hf4};
        i_mem.prog[5] = {6'(OP_INTERRUPT_EXIT), 11'h000};
        i_mem.prog[8] = {6'(op), 11'h000};
        i_mem.prog[11'h710] = tb;
        i_mem.dmem[8'h10] = m;
        run(irq, n, where, val, acks);
        expect_ops(op, a, m, opd, tb[7:0], b, ra, rm, rc, rz, dl);
        if (program_counter_low) rm = m;
        if (program_counter_low) dl = 4;
        if (irq) dl = 16;
        land = ((dl == 4 && op != OP_TABLE_READ) || program_counter_low) ? 8'hf0 : 8'hf2;
        if (base == 0) base = n;
        `CHK("cycles", dl, n - base)
        `CHK("landing", land, where)
        `CHK("stored acc", ra, val)
        `CHK("acc", ra, acc)
        `CHK("memory", rm, i_mem.dmem[8'h10])
        `CHK("carry", rc, carry)
        `CHK("zero", rz, zero)
        `CHK("acks", int'(irq), acks)
    endtask : try

    task automatic stop_test();
        $display("Checks made %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // The first run is a no-op and sets the reference time; every operation follows
    // with zero, all-ones and random memory operands.
    initial begin
        void'($urandom(16152));
        try(OP_NOP, 3'h0, 8'h10, 8'h5a, 8'h33, 1'b0);
        for (int rep = 0; rep < 3; rep++) begin
            for (int k = 0; k < 39; k++) begin
                try(mitc_op_e'(k), 3'($urandom), 8'h10, 8'($urandom),
                    (rep == 0) ? 8'h00 : (rep == 1) ? 8'hff : 8'($urandom), 1'b0);
            end
        end
        try(OP_DATA_TRANSFER_MA, 3'h0, 8'h06, 8'h03, 8'h55, 1'b0);
        try(OP_NOP, 3'h0, 8'h10, 8'ha5, 8'h00, 1'b1);
        try(OP_ADD_AM, 3'h0, 8'h10, 8'hff, 8'h01, 1'b0);
        try(OP_SUB_AM, 3'h0, 8'h10, 8'h00, 8'h01, 1'b0);
        stop_test();
    end

    // About 120 runs of some 16 to 32 clocks each; the limit leaves ample margin.
    initial begin
        #(40 * 40000);
        bad_count++;
        stop_test();
    end
endmodule : mitc_instruction_timing_core_bench
`default_nettype wire
